//--- inc/trip_pkg.sv
// package: register map, field limits, timing constants for the trip relay logic
`default_nettype none
package trip_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ACCESS = 8'h04;
  localparam logic [7:0] OFS_FILT = 8'h08;
  localparam logic [7:0] OFS_R1_SET = 8'h0c;
  localparam logic [7:0] OFS_R1_BAND = 8'h10;
  localparam logic [7:0] OFS_R1_DLY = 8'h14;
  localparam logic [7:0] OFS_R1_WHYS = 8'h18;
  localparam logic [7:0] OFS_R2_SET = 8'h1c;
  localparam logic [7:0] OFS_R2_BAND = 8'h20;
  localparam logic [7:0] OFS_R2_DLY = 8'h24;
  localparam logic [7:0] OFS_R2_WHYS = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2c;
  // control field positions
  localparam int CTRL_FUNC_LSB = 0;
  localparam int CTRL_R1_FALL = 4;
  localparam int CTRL_R2_FALL = 5;
  localparam int CTRL_AC = 6;
  localparam int CTRL_QUICK = 7;
  // functions
  localparam logic [2:0] FN_SINGLE = 3'h1;
  localparam logic [2:0] FN_DUAL = 3'h2;
  localparam logic [2:0] FN_PRE = 3'h3;
  localparam logic [2:0] FN_WINDOW = 3'h4;
  localparam logic [2:0] FN_HOLD = 3'h5;
  // limits, tenths of percent / tenths of second
  localparam logic [9:0] PCT_MAX = 10'h3e7;
  localparam logic [9:0] DLY_MAX = 10'h3e7;
  localparam logic [9:0] ACCESS_MAX = 10'h3e7;
  localparam logic [9:0] ACCESS_UNLOCK = 10'h028;
  localparam logic [9:0] FILT_MIN = 10'h002;
  localparam logic [9:0] FILT_MAX = 10'h258;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [9:0] ACCESS_RST = 10'h028;
  localparam logic [9:0] FILT_RST = 10'h002;
  // tick: 0.1 s at 40 MHz
  localparam int CLK_HZ = 40000000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
endpackage : trip_pkg
`default_nettype wire

//--- verilog/trip_channel.sv
// one relay channel: hysteretic trip decision with persistence delay
`timescale 1ns/1ps
`default_nettype none
module trip_channel (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick,
  // decision inputs
  input wire logic want_on,
  input wire logic want_off,
  input wire logic [9:0] delay,
  input wire logic enable,
  // relay state
  output logic relay_ff
);
  import trip_pkg::*;
  logic [9:0] cnt_ff;
  logic cond;
  logic nxt_relay;
  // condition asking for the other state
  assign cond = relay_ff ? want_off : want_on;
  assign nxt_relay = (cnt_ff >= delay) ? ~relay_ff : relay_ff;
  // counter restarts whenever the condition lapses, so only an unbroken stretch switches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 10'h000;
      relay_ff <= 1'b0;
    end else if (!enable) begin
      cnt_ff <= 10'h000;
      relay_ff <= 1'b0;
    end else if (!cond) begin
      cnt_ff <= 10'h000;
    end else if (cnt_ff >= delay) begin
      relay_ff <= nxt_relay;
      cnt_ff <= 10'h000;
    end else if (tick) begin
      cnt_ff <= cnt_ff + 10'h001;
    end
  end
endmodule : trip_channel
`default_nettype wire

//--- verilog/trip_relay_logic.sv
// trip relay logic top: ahb-lite registers, input filter, function decode, two channels
// Operation
// - input smoothed by exponential filter, response 0.2 to 60.0 s.
// - programmed response below input-type minimum is replaced by that minimum.
// - dc or ac input handling selectable as configuration bit.
// - setpoints and bands 0..99.9 percent, delays 0..99.9 s accepted.
// - single setpoint drives relay 1 only; relay 2 stays off.
// - dual setpoint runs two independent channels with own parameters.
// - pre-setpoint forces relay 1 to rising-trip direction.
// - pre-setpoint relay 2 trips at relay 1 setpoint minus offset, own band.
// - pre-setpoint ignores relay 2 direction and window band.
// - window mode: rising energises inside window, falling de-energises inside.
// - window band lies outside limits, widening the leaving threshold.
// - hold: relay 2 latches at its setpoint, releases at relay 1 setpoint.
// - hold uses relay 2 delay, ignores relay 2 band and direction.
// - hold keeps relay 1 an ordinary trip channel.
// - quick adjust permit bit held in control register.
// - access code 0..999; parameter writes allowed only when code equals 40.
// - rising trips above setpoint, releases below setpoint minus band; falling mirrored.
// - relay switches only after condition persists for programmed delay.
`timescale 1ns/1ps
`default_nettype none
module trip_relay_logic #(
  parameter int TICK_DIV = trip_pkg::TICK_CYCLES,
  parameter logic [9:0] FILT_MIN_AC = 10'h00a
) (
  // ahb-lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // measurement, percent of span in tenths, sampled on the same clock
  input wire logic [9:0] meas_in,
  input wire logic meas_valid,
  input wire logic relay_clear,
  // relay drive
  output logic relay1_out,
  output logic relay2_out,
  output logic quick_adjust_on
);
  import trip_pkg::*;
  initial begin
    if (TICK_DIV < 2) $error("TICK_DIV too small");
    if (FILT_MIN_AC < FILT_MIN || FILT_MIN_AC > FILT_MAX) $error("FILT_MIN_AC out of range");
  end

  // clamp a written value to its legal maximum
  function automatic logic [9:0] clamp(input logic [31:0] v, input logic [9:0] mx);
    clamp = (v > {22'h0, mx}) ? mx : v[9:0];
  endfunction : clamp

  // ---- bus slave: latch address phase, act in data phase, zero wait states
  logic wr_pend_ff;
  logic [7:0] addr_ff;
  logic [7:0] ctrl_ff;
  logic [9:0] access_ff, filt_ff;
  logic [9:0] r1_set_ff, r1_band_ff, r1_dly_ff, r1_whys_ff;
  logic [9:0] r2_set_ff, r2_band_ff, r2_dly_ff, r2_whys_ff;
  logic rd_sel;
  logic [31:0] rd_mux;
  logic unlocked;
  logic wr_param;
  logic wr_access;
  logic relay1_q, relay2_q;
  logic [9:0] filt_val_ff;
  logic [9:0] filt_wr;
  assign rd_sel = hsel && hready && htrans[1] && !hwrite;
  // whole word compared, so a large write is not cut to its low bits before clamping
  assign filt_wr = (hwdata < {22'h0, FILT_MIN}) ? FILT_MIN : clamp(hwdata, FILT_MAX);
  assign unlocked = (access_ff == ACCESS_UNLOCK);
  assign wr_access = wr_pend_ff && (addr_ff == OFS_ACCESS);
  assign wr_param = wr_pend_ff && unlocked && !wr_access;
  // read multiplexer; unmapped words read as zero
  always_comb begin
    rd_mux = 32'h0;
    case (haddr)
      OFS_CTRL: rd_mux = {24'h0, ctrl_ff};
      OFS_ACCESS: rd_mux = {22'h0, access_ff};
      OFS_FILT: rd_mux = {22'h0, filt_ff};
      OFS_R1_SET: rd_mux = {22'h0, r1_set_ff};
      OFS_R1_BAND: rd_mux = {22'h0, r1_band_ff};
      OFS_R1_DLY: rd_mux = {22'h0, r1_dly_ff};
      OFS_R1_WHYS: rd_mux = {22'h0, r1_whys_ff};
      OFS_R2_SET: rd_mux = {22'h0, r2_set_ff};
      OFS_R2_BAND: rd_mux = {22'h0, r2_band_ff};
      OFS_R2_DLY: rd_mux = {22'h0, r2_dly_ff};
      OFS_R2_WHYS: rd_mux = {22'h0, r2_whys_ff};
      OFS_STATUS: rd_mux = {20'h0, filt_val_ff, relay2_q, relay1_q};
      default: rd_mux = 32'h0;
    endcase
  end
  // address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      addr_ff <= 8'h00;
      hrdata <= 32'h0;
    end else begin
      wr_pend_ff <= hsel && hready && htrans[1] && hwrite;
      addr_ff <= haddr;
      if (rd_sel) hrdata <= rd_mux;
    end
  end
  // ready from the first clock after reset, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  // parameter store; the access code itself stays writable so it can be unlocked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= CTRL_RST;
      access_ff <= ACCESS_RST;
      filt_ff <= FILT_RST;
      r1_set_ff <= 10'h0;
      r1_band_ff <= 10'h0;
      r1_dly_ff <= 10'h0;
      r1_whys_ff <= 10'h0;
      r2_set_ff <= 10'h0;
      r2_band_ff <= 10'h0;
      r2_dly_ff <= 10'h0;
      r2_whys_ff <= 10'h0;
    end else begin
      if (wr_access) access_ff <= clamp(hwdata, ACCESS_MAX);
      if (wr_param) begin
        case (addr_ff)
          OFS_CTRL: ctrl_ff <= hwdata[7:0];
          OFS_FILT: filt_ff <= filt_wr;
          OFS_R1_SET: r1_set_ff <= clamp(hwdata, PCT_MAX);
          OFS_R1_BAND: r1_band_ff <= clamp(hwdata, PCT_MAX);
          OFS_R1_DLY: r1_dly_ff <= clamp(hwdata, DLY_MAX);
          OFS_R1_WHYS: r1_whys_ff <= clamp(hwdata, PCT_MAX);
          OFS_R2_SET: r2_set_ff <= clamp(hwdata, PCT_MAX);
          OFS_R2_BAND: r2_band_ff <= clamp(hwdata, PCT_MAX);
          OFS_R2_DLY: r2_dly_ff <= clamp(hwdata, DLY_MAX);
          OFS_R2_WHYS: r2_whys_ff <= clamp(hwdata, PCT_MAX);
          default: ;
        endcase
      end
    end
  end

  // ---- 0.1 s tick divider
  logic [31:0] div_ff;
  logic tick_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_ff <= 32'h0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (div_ff == 32'(TICK_DIV - 1));
      div_ff <= (div_ff == 32'(TICK_DIV - 1)) ? 32'h0 : div_ff + 32'h1;
    end
  end

  // ---- exponential filter: y += (x - y) * tick / response, in fixed point
  // a tick step per 0.1 s keeps the arithmetic small; resolution is coarse at short times
  logic [9:0] resp_eff;
  logic [23:0] acc_ff;
  logic signed [25:0] diff;
  logic signed [25:0] step;
  assign resp_eff = (ctrl_ff[CTRL_AC] && filt_ff < FILT_MIN_AC) ? FILT_MIN_AC : filt_ff;
  assign diff = $signed({2'b00, meas_in, 14'h0}) - $signed({2'b00, acc_ff});
  assign step = diff / $signed({16'h0, resp_eff});
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_ff <= 24'h0;
      filt_val_ff <= 10'h0;
    end else begin
      if (tick_ff && meas_valid) acc_ff <= 24'($signed({2'b00, acc_ff}) + step);
      filt_val_ff <= acc_ff[23:14];
    end
  end

  // ---- function decode
  logic [2:0] fn;
  logic [10:0] x, s1, b1, s2, b2, w1, w2, r1_hi, r2_hi, pre_sp;
  logic r1_fall, r2_fall, is_win, is_pre, is_hold, is_single;
  logic r1_on, r1_off, r2_on, r2_off, r2_en;
  assign fn = ctrl_ff[CTRL_FUNC_LSB +: 3];
  assign is_single = (fn == FN_SINGLE) || !(fn inside {FN_DUAL, FN_PRE, FN_WINDOW, FN_HOLD});
  assign is_pre = (fn == FN_PRE);
  assign is_win = (fn == FN_WINDOW);
  assign is_hold = (fn == FN_HOLD);
  assign x = {1'b0, filt_val_ff};
  assign s1 = {1'b0, r1_set_ff};
  assign b1 = {1'b0, r1_band_ff};
  assign s2 = {1'b0, r2_set_ff};
  assign b2 = {1'b0, r2_band_ff};
  assign w1 = {1'b0, r1_whys_ff};
  assign w2 = {1'b0, r2_whys_ff};
  assign r1_hi = b1; // upper window limit shares the band register
  assign r2_hi = b2;
  assign r1_fall = ctrl_ff[CTRL_R1_FALL] && !is_pre;
  assign r2_fall = ctrl_ff[CTRL_R2_FALL];
  assign pre_sp = (s1 > s2) ? s1 - s2 : 11'h0;
  // inside-window test, leaving only beyond the band outside the limits
  function automatic logic win_in(input logic [10:0] v, lo, hi, hy);
    win_in = (v >= lo) && (v <= hi);
  endfunction : win_in
  function automatic logic win_out(input logic [10:0] v, lo, hi, hy);
    win_out = (v + hy < lo) || (v > hi + hy);
  endfunction : win_out
  // relay 1 trip conditions
  always_comb begin
    if (is_win) begin
      r1_on = r1_fall ? win_out(x, s1, r1_hi, w1) : win_in(x, s1, r1_hi, w1);
      r1_off = r1_fall ? win_in(x, s1, r1_hi, w1) : win_out(x, s1, r1_hi, w1);
    end else if (r1_fall) begin
      r1_on = x < s1;
      r1_off = x > s1 + b1;
    end else begin
      r1_on = x > s1;
      r1_off = x + b1 < s1;
    end
  end
  // relay 2 trip conditions per function
  always_comb begin
    r2_en = !is_single;
    if (is_win) begin
      r2_on = r2_fall ? win_out(x, s2, r2_hi, w2) : win_in(x, s2, r2_hi, w2);
      r2_off = r2_fall ? win_in(x, s2, r2_hi, w2) : win_out(x, s2, r2_hi, w2);
    end else if (is_pre) begin
      r2_on = x > pre_sp;
      r2_off = x + b2 < pre_sp;
    end else if (is_hold) begin
      r2_on = x >= s2;
      r2_off = x <= s1;
    end else if (r2_fall) begin
      r2_on = x < s2;
      r2_off = x > s2 + b2;
    end else begin
      r2_on = x > s2;
      r2_off = x + b2 < s2;
    end
  end

  // ---- channels
  trip_channel u_ch1 (
    .hclk(hclk), .hresetn(hresetn), .tick(tick_ff),
    .want_on(r1_on), .want_off(r1_off), .delay(r1_dly_ff),
    .enable(!relay_clear), .relay_ff(relay1_q)
  );
  trip_channel u_ch2 (
    .hclk(hclk), .hresetn(hresetn), .tick(tick_ff),
    .want_on(r2_on), .want_off(r2_off), .delay(r2_dly_ff),
    .enable(r2_en && !relay_clear), .relay_ff(relay2_q)
  );
  // registered drive outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      relay1_out <= 1'b0;
      relay2_out <= 1'b0;
      quick_adjust_on <= 1'b0;
    end else begin
      relay1_out <= relay1_q && !relay_clear;
      relay2_out <= relay2_q && r2_en && !relay_clear;
      quick_adjust_on <= ctrl_ff[CTRL_QUICK];
    end
  end

  // ---- assertions
  property p_single_off;
    @(posedge hclk) disable iff (!hresetn) is_single |=> !relay2_out;
  endproperty
  a_single_off: assert property (p_single_off) else $error("relay 2 on in single mode");
  property p_locked;
    @(posedge hclk) disable iff (!hresetn) (wr_pend_ff && !unlocked && addr_ff == OFS_R1_SET)
      |=> $stable(r1_set_ff);
  endproperty
  a_locked: assert property (p_locked) else $error("write while locked");
  property p_clear;
    @(posedge hclk) disable iff (!hresetn) relay_clear |=> !relay1_out && !relay2_out;
  endproperty
  a_clear: assert property (p_clear) else $error("relay active under clear");
  property p_pct_max;
    @(posedge hclk) disable iff (!hresetn) r1_set_ff <= PCT_MAX && r2_dly_ff <= DLY_MAX;
  endproperty
  a_pct_max: assert property (p_pct_max) else $error("setting beyond maximum");
  property p_resp_min;
    @(posedge hclk) disable iff (!hresetn) ctrl_ff[CTRL_AC] |-> resp_eff >= FILT_MIN_AC;
  endproperty
  a_resp_min: assert property (p_resp_min) else $error("response below minimum");
  property p_filt_rng;
    @(posedge hclk) disable iff (!hresetn) filt_ff >= FILT_MIN && filt_ff <= FILT_MAX;
  endproperty
  a_filt_rng: assert property (p_filt_rng) else $error("response out of range");
  property p_persist;
    @(posedge hclk) disable iff (!hresetn) ($rose(relay1_q) && r1_dly_ff != 10'h0) |-> $past(r1_on);
  endproperty
  a_persist: assert property (p_persist) else $error("relay 1 switched without cause");
  property p_tick;
    @(posedge hclk) disable iff (!hresetn) tick_ff |=> !tick_ff;
  endproperty
  a_tick: assert property (p_tick) else $error("tick longer than one cycle");
  property p_quick;
    @(posedge hclk) disable iff (!hresetn) ##1 quick_adjust_on == $past(ctrl_ff[CTRL_QUICK]);
  endproperty
  a_quick: assert property (p_quick) else $error("quick adjust mismatch");
  c_r1: cover property (@(posedge hclk) $rose(relay1_out));
  c_hold: cover property (@(posedge hclk) is_hold && $rose(relay2_out));
  c_win: cover property (@(posedge hclk) is_win && relay1_out);
endmodule : trip_relay_logic
`default_nettype wire

//--- tb/trip_process_model.sv
// process side model: digitised measurement source feeding the trip logic
`timescale 1ns/1ps
`default_nettype none
module trip_process_model #(
  parameter int STALL = 0
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // level requested by the bench, percent of span in tenths
  input wire logic [9:0] level,
  // measurement towards the block
  output logic [9:0] meas_in,
  output logic meas_valid
);
  logic [2:0] phase_ff;

  // converter output never exceeds full span; a slow converter drops valid for STALL cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_ff <= 3'h0;
      meas_in <= 10'h000;
      meas_valid <= 1'b0;
    end else begin
      phase_ff <= phase_ff + 3'h1;
      meas_in <= (level > 10'h3e7) ? 10'h3e7 : level;
      meas_valid <= (int'(phase_ff) >= STALL);
    end
  end
endmodule : trip_process_model
`default_nettype wire

//--- tb/trip_relay_logic_bench.sv
// self-checking bench for the trip relay logic
`timescale 1ns/1ps
`default_nettype none
module trip_relay_logic_bench;
  import trip_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic relay_clear = 1'b0;
  logic [9:0] level = 10'h000;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout, hresp, relay1_out, relay2_out, quick_adjust_on, meas_valid;
  logic [9:0] meas_in;
  int errors = 0;
  int compares = 0;
  int cycles = 0;

  always #12.5 hclk = ~hclk;
  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  trip_process_model #(.STALL(0)) far (.hclk(hclk), .hresetn(hresetn), .level(level),
    .meas_in(meas_in), .meas_valid(meas_valid));

  // tick shortened to 10 cycles so delays stay short in simulation
  trip_relay_logic #(.TICK_DIV(10)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .meas_in(meas_in), .meas_valid(meas_valid), .relay_clear(relay_clear),
    .relay1_out(relay1_out), .relay2_out(relay2_out), .quick_adjust_on(quick_adjust_on));

  task automatic wrap_up();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // hang guard: the whole run needs well under this many cycles
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors = errors + 1;
      wrap_up();
    end
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit

  // one single ahb-lite transfer; address held until ready, then data phase until ready
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk_reg(q, exp);
  endtask : rd

  task automatic relays(input logic e1, input logic e2);
    chk_bit(relay1_out, e1);
    chk_bit(relay2_out, e2);
  endtask : relays

  // move the process and poll the filtered value until it sits near the target
  task automatic settle(input logic [9:0] v);
    logic [31:0] q;
    int n;
    int d;
    level <= v;
    n = 0;
    do begin
      bus(OFS_STATUS, 1'b0, 32'h0, q);
      d = int'(q[11:2]) - int'(v);
      n++;
    end while ((d > 3 || d < -3) && n < 600);
    chk_bit(d <= 3 && d >= -3, 1'b1);
    repeat (10) @(posedge hclk);
  endtask : settle

  task automatic cfg(input logic [7:0] c, input logic [9:0] s1, b1, s2, b2);
    wr(OFS_CTRL, {24'h0, c});
    wr(OFS_R1_SET, {22'h0, s1});
    wr(OFS_R1_BAND, {22'h0, b1});
    wr(OFS_R2_SET, {22'h0, s2});
    wr(OFS_R2_BAND, {22'h0, b2});
    wr(OFS_R1_DLY, 32'h0);
    wr(OFS_R2_DLY, 32'h0);
  endtask : cfg

  task automatic t_reset();
    rd(OFS_CTRL, {24'h0, CTRL_RST});
    rd(OFS_ACCESS, 32'h28);
    rd(OFS_FILT, 32'h2);
    rd(8'h30, 32'h0);
    chk_bit(quick_adjust_on, 1'b0);
    chk_bit(hresp, 1'b0);
    chk_bit(hreadyout, 1'b1);
    relays(1'b0, 1'b0);
  endtask : t_reset

  task automatic t_access();
    wr(OFS_ACCESS, 32'h5);
    wr(OFS_CTRL, 32'h82);
    rd(OFS_CTRL, 32'h01);
    wr(OFS_ACCESS, 32'h3000);
    rd(OFS_ACCESS, 32'h3e7);
    wr(OFS_ACCESS, 32'h28);
    wr(OFS_CTRL, 32'hc1);
    rd(OFS_CTRL, 32'hc1);
    chk_bit(quick_adjust_on, 1'b1);
    wr(OFS_CTRL, 32'h01);
    rd(OFS_CTRL, 32'h01);
    chk_bit(quick_adjust_on, 1'b0);
  endtask : t_access

  task automatic t_clamp();
    wr(OFS_R1_SET, 32'h500);
    rd(OFS_R1_SET, 32'h3e7);
    wr(OFS_R2_DLY, 32'hffff);
    rd(OFS_R2_DLY, 32'h3e7);
    wr(OFS_FILT, 32'h0);
    rd(OFS_FILT, 32'h2);
    wr(OFS_FILT, 32'h1000);
    rd(OFS_FILT, 32'h258);
    wr(OFS_FILT, 32'h2);
  endtask : t_clamp

  task automatic t_modes();
    cfg(8'h01, 10'h1f4, 10'h032, 10'h064, 10'h000);
    settle(10'h258);
    relays(1'b1, 1'b0);
    settle(10'h1d6);
    relays(1'b1, 1'b0);
    settle(10'h1b8);
    relays(1'b0, 1'b0);
    cfg(8'h22, 10'h1f4, 10'h032, 10'h12c, 10'h014);
    settle(10'h0c8);
    relays(1'b0, 1'b1);
    settle(10'h258);
    relays(1'b1, 1'b0);
    cfg(8'h33, 10'h1f4, 10'h032, 10'h032, 10'h005);
    settle(10'h064);
    relays(1'b0, 1'b0);
    settle(10'h1d6);
    relays(1'b0, 1'b1);
    settle(10'h258);
    relays(1'b1, 1'b1);
    settle(10'h1ae);
    relays(1'b0, 1'b0);
  endtask : t_modes

  task automatic t_window_hold();
    cfg(8'h24, 10'h12c, 10'h258, 10'h12c, 10'h258);
    wr(OFS_R1_WHYS, 32'h14);
    wr(OFS_R2_WHYS, 32'h14);
    settle(10'h1c2);
    relays(1'b1, 1'b0);
    settle(10'h262);
    relays(1'b1, 1'b0);
    settle(10'h2bc);
    relays(1'b0, 1'b1);
    cfg(8'h25, 10'h12c, 10'h014, 10'h258, 10'h1f4);
    settle(10'h0c8);
    relays(1'b0, 1'b0);
    settle(10'h28a);
    relays(1'b1, 1'b1);
    settle(10'h190);
    relays(1'b1, 1'b1);
    settle(10'h0fa);
    relays(1'b0, 1'b0);
  endtask : t_window_hold

  task automatic t_delay();
    int n;
    cfg(8'h01, 10'h2bc, 10'h00a, 10'h000, 10'h000);
    settle(10'h258);
    relays(1'b0, 1'b0);
    wr(OFS_R1_DLY, 32'h5);
    wr(OFS_R1_SET, 32'h1f4);
    repeat (30) @(posedge hclk);
    chk_bit(relay1_out, 1'b0);
    n = 0;
    while (relay1_out !== 1'b1 && n < 60) begin
      @(posedge hclk);
      n++;
    end
    chk_bit(relay1_out, 1'b1);
    relay_clear <= 1'b1;
    repeat (3) @(posedge hclk);
    relays(1'b0, 1'b0);
    relay_clear <= 1'b0;
    repeat (30) @(posedge hclk);
    chk_bit(relay1_out, 1'b0);
    n = 0;
    while (relay1_out !== 1'b1 && n < 60) begin
      @(posedge hclk);
      n++;
    end
    chk_bit(relay1_out, 1'b1);
  endtask : t_delay

  // ac input: a 0.2 s response is raised to the ac minimum, so the fall is slow
  task automatic t_ac_min();
    logic [31:0] q;
    wr(OFS_CTRL, 32'h41);
    level <= 10'h000;
    repeat (20) @(posedge hclk);
    bus(OFS_STATUS, 1'b0, 32'h0, q);
    chk_bit(q[11:2] > 10'h12c, 1'b1);
  endtask : t_ac_min

  // main sequence: reset for four cycles, then each scenario in turn
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_access();
    t_clamp();
    t_modes();
    t_window_hold();
    t_delay();
    t_ac_min();
    wrap_up();
  end
endmodule : trip_relay_logic_bench
`default_nettype wire
